// File: rtl/slave_sync_pkg.sv
package slave_sync_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ctrl_one_offset = 8'h00;
	localparam logic [7:0] ctrl_two_offset = 8'h04;
	localparam logic [7:0] slave_ctrl_offset = 8'h08;
	localparam logic [7:0] irq_dma_enable_offset = 8'h0C;
	localparam logic [7:0] status_offset = 8'h10;
	localparam logic [7:0] event_gen_offset = 8'h14;
	localparam logic [7:0] counter_offset = 8'h24;
	localparam logic [7:0] autoreload_offset = 8'h2C;
	localparam logic [7:0] compare_one_offset = 8'h34;
	localparam logic [7:0] lock_level_offset = 8'h44;
	localparam logic [15:0] ctrl_one_reset = 16'h0000;
	localparam logic [15:0] ctrl_two_reset = 16'h0000;
	localparam logic [15:0] autoreload_reset = 16'hFFFF;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int cen_pos = 0;
	localparam int update_disable_pos = 1;
	localparam int urs_pos = 2;
	localparam int opm_pos = 3;
	localparam int autoreload_buffer_enable_pos = 7;
	localparam int ckd_lsb = 8;
	localparam int control_preload_enable_pos = 0;
	localparam int ccus_pos = 2;
	localparam int channel_dma_select_pos = 3;
	localparam int mms_lsb = 4;
	localparam int ch1_idle_level_pos = 8;
	localparam int ch1_comp_idle_level_pos = 9;
	localparam int ch2_idle_level_pos = 10;
	localparam int sms_lsb = 0;
	localparam int ts_lsb = 4;
	localparam int tie_pos = 6;
	localparam int tde_pos = 14;
	localparam int tif_pos = 6;
	localparam int ug_pos = 0;
	localparam int commutation_generate_pos = 5;
	localparam logic [15:0] ctrl_one_mask = 16'h038F;
	localparam logic [15:0] ctrl_two_mask = 16'h077D;
	localparam logic [15:0] ois_mask = 16'h0700;
	localparam logic [15:0] slave_ctrl_mask = 16'h0077;
	localparam logic [15:0] irq_dma_mask = 16'h4040;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] sms_disabled = 3'h0;
	localparam logic [2:0] sms_reset = 3'h4;
	localparam logic [2:0] sms_gated = 3'h5;
	localparam logic [2:0] sms_trigger = 3'h6;
	localparam logic [2:0] sms_ext_clock = 3'h7;
	localparam logic [2:0] mms_reset = 3'h0;
	localparam logic [2:0] mms_enable = 3'h1;
	localparam logic [2:0] mms_update = 3'h2;
	localparam logic [2:0] mms_cmp_pulse = 3'h3;
	localparam logic [2:0] mms_ch1_ref = 3'h4;
	localparam logic [2:0] mms_ch2_ref = 3'h5;
	localparam logic [1:0] ckd_div1 = 2'h0;
	localparam logic [1:0] ckd_div2 = 2'h1;
	localparam logic [1:0] ckd_div4 = 2'h2;
	localparam int clock_mhz = 40;

	typedef struct packed {
		logic [7:0] adr;
		logic [15:0] dat;
		logic [1:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} wb_req_type;

	typedef struct packed {
		logic [15:0] dat;
		logic ack;
	} wb_rsp_type;

	typedef struct packed {
		logic [3:0] internal_trigger;
		logic input_pin_one;
		logic input_pin_two;
		logic ch1_reference;
		logic ch2_reference;
		logic ch1_match;
		logic debug_halted;
		logic debug_halt_freeze;
		logic main_output_enable;
	} trig_in_type;

	typedef struct packed {
		logic trigger_output;
		logic trigger_irq;
		logic trigger_dma;
		logic update_irq;
		logic update_event;
		logic ch_dma_strobe;
		logic control_transfer;
		logic sample_tick;
		logic ch1_idle_level;
		logic ch1_comp_idle_level;
		logic ch2_idle_level;
		logic idle_active;
	} trig_out_type;
endpackage : slave_sync_pkg

// File: rtl/timer_slave_sync_control.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - Reset mode trigger clears counter and prescaler
// RULE_02 - Reset trigger with UPDATE_SOURCE_RESTRICT clear raises update
// RULE_03 - Reset trigger sets flag, irq, dma
// RULE_04 - Gated mode counts only while trigger high
// RULE_05 - Gated mode needs software counter enable
// RULE_06 - Gated mode flags both gate edges
// RULE_07 - Trigger mode rising edge starts counter
// RULE_08 - Trigger mode sets enable bit by hardware
// RULE_09 - Debug halt freezes counter when chosen
// RULE_10 - Clock division gives 1, 2, 4 tick period
// RULE_11 - Autoreload buffered when buffer bit set
// RULE_12 - One-pulse clears enable at update
// RULE_13 - Update-source bit restricts update request
// RULE_14 - Update disable blocks update, still reinitializes
// RULE_15 - Update event loads all shadow registers; code loads arr and compare shadows, not prescale_shadow_q
// RULE_16 - Output enable low drives idle levels
// RULE_17 - Idle bits locked by lock level
// RULE_18 - Master mode selects trigger output source
// RULE_19 - Enable output ORs enable and gate
// RULE_20 - Compare pulse on every channel one match
// RULE_21 - Channel dma on event or on update
// RULE_22 - Preloaded controls move on commutation
// RULE_23 - Trigger select picks internal or pin source
// RULE_24 - Slave mode field encodings
// RULE_25 - Trigger input synchronised before detection
module timer_slave_sync_control (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register bus
	input wire slave_sync_pkg::wb_req_type wb_req,
	output slave_sync_pkg::wb_rsp_type wb_rsp,
	// Trigger sources and outputs
	input wire slave_sync_pkg::trig_in_type trig_in,
	output slave_sync_pkg::trig_out_type trig_out,
	output logic [15:0] counter_value
);
	import slave_sync_pkg::*;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] ctrl_one_q, ctrl_two_q, slave_ctrl_q, irq_dma_q;
	logic [15:0] counter_q, prescale_q, prescale_shadow_q;
	logic [15:0] arr_preload_q, arr_shadow_q, cmp_preload_q, cmp_shadow_q;
	logic [1:0] lock_q;
	logic trigger_flag_q, update_flag_q, ack_q;
	logic [15:0] rdata_q;
	logic sync1_q, sync2_q, trig_prev_q, pin_one_prev_q;
	logic [1:0] div_q;
	logic tick_q, ctrl_pending_q, ctrl_xfer_q, trigger_output_q, chdma_q;
	logic gate_prev_q;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	wire access = wb_req.cyc && wb_req.stb && !ack_q;
	// Writes land at the edge where the master samples ack high
	wire wr = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
	wire wr_lo = wr && wb_req.sel[0];
	wire wr_hi = wr && wb_req.sel[1];
	wire [15:0] lane_mask = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
	wire wr_any = wr_lo || wr_hi;
	wire hit_c1 = wb_req.adr == ctrl_one_offset;
	wire hit_c2 = wb_req.adr == ctrl_two_offset;
	wire hit_smc = wb_req.adr == slave_ctrl_offset;
	wire hit_ie = wb_req.adr == irq_dma_enable_offset;
	wire hit_sr = wb_req.adr == status_offset;
	wire hit_eg = wb_req.adr == event_gen_offset;
	wire hit_cnt = wb_req.adr == counter_offset;
	wire hit_arr = wb_req.adr == autoreload_offset;
	wire hit_cmp = wb_req.adr == compare_one_offset;
	wire hit_lck = wb_req.adr == lock_level_offset;
	wire [15:0] wmask = wr_any ? lane_mask : 16'h0000;
	wire sw_update = wr_lo && hit_eg && wb_req.dat[ug_pos];
	wire sw_commute = wr_lo && hit_eg && wb_req.dat[commutation_generate_pos];

	// ---------------------------------------------------------------
	// Trigger select and synchroniser
	// ---------------------------------------------------------------
	wire [2:0] slave_mode_field = slave_ctrl_q[sms_lsb +: 3];
	wire [2:0] ts = slave_ctrl_q[ts_lsb +: 3];
	wire [2:0] master_mode_field = ctrl_two_q[mms_lsb +: 3];
	logic raw_trig;
	always_comb
	begin
		case (ts) // RULE_23
			3'h0, 3'h1, 3'h2, 3'h3: raw_trig = trig_in.internal_trigger[ts[1:0]];
			3'h4: raw_trig = trig_in.input_pin_one ^ pin_one_prev_q;
			3'h5: raw_trig = trig_in.input_pin_one;
			3'h6: raw_trig = trig_in.input_pin_two;
			default: raw_trig = 1'b0;
		endcase
	end
	// Edge-detector source pulses once for every change of pin one
	wire trig_level = sync2_q; // RULE_25
	wire trig_rise = sync2_q && !trig_prev_q;
	wire trig_fall = !sync2_q && trig_prev_q;

	// ---------------------------------------------------------------
	// Slave controller
	// ---------------------------------------------------------------
	wire counter_enable_bit = ctrl_one_q[cen_pos];
	wire update_disable = ctrl_one_q[update_disable_pos];
	wire update_source_restrict = ctrl_one_q[urs_pos];
	wire one_pulse_mode = ctrl_one_q[opm_pos];
	wire autoreload_buffer_enable = ctrl_one_q[autoreload_buffer_enable_pos];
	wire mode_reset = slave_mode_field == sms_reset; // RULE_24
	wire mode_gated = slave_mode_field == sms_gated;
	wire mode_trig = slave_mode_field == sms_trigger;
	wire mode_ext = slave_mode_field == sms_ext_clock;
	wire slave_reset = mode_reset && trig_rise; // RULE_01
	wire trig_start = mode_trig && trig_rise && !counter_enable_bit; // RULE_07
	wire gate_open = mode_gated && counter_enable_bit && trig_level; // RULE_04 RULE_05
	wire gate_edge = mode_gated && counter_enable_bit && (gate_open != gate_prev_q); // RULE_06
	wire trig_event = slave_reset || (mode_trig && trig_rise)
		|| (mode_ext && trig_rise) || gate_edge; // RULE_03
	wire frozen = trig_in.debug_halted && trig_in.debug_halt_freeze; // RULE_09
	wire run = (mode_gated ? gate_open : counter_enable_bit) && !frozen;
	wire clk_en = mode_ext ? trig_rise : 1'b1;
	wire pre_wrap = prescale_q >= prescale_shadow_q;
	wire cnt_step = run && clk_en && pre_wrap;
	wire overflow = cnt_step && counter_q >= arr_shadow_q;
	wire reinit = slave_reset || sw_update; // RULE_14
	wire update_event = !update_disable && (overflow || reinit); // RULE_14 RULE_15
	wire update_req = update_event && (overflow || !update_source_restrict); // RULE_02 RULE_13
	wire ch1_event = trig_in.ch1_match;
	wire [15:0] arr_eff = autoreload_buffer_enable ? arr_shadow_q : arr_preload_q; // RULE_11
	wire locked = lock_q != 2'h0;
	wire [15:0] c2_wmask = locked ? (wmask & ~ois_mask) : wmask; // RULE_17

	// Counter enable bit: software write, trigger start, one-pulse stop
	logic [15:0] c1_d;
	always_comb
	begin
		c1_d = ctrl_one_q;
		if (hit_c1)
			c1_d = (ctrl_one_q & ~wmask) | (wb_req.dat & wmask & ctrl_one_mask);
		if (trig_start)
			c1_d[cen_pos] = 1'b1; // RULE_08
		if (one_pulse_mode && update_event)
			c1_d[cen_pos] = 1'b0; // RULE_12
	end

	// Trigger output source selection
	logic trigger_output_d;
	always_comb
	begin
		case (master_mode_field) // RULE_18
			mms_reset: trigger_output_d = reinit;
			mms_enable: trigger_output_d = counter_enable_bit || (mode_gated && trig_level); // RULE_19
			mms_update: trigger_output_d = update_event;
			mms_cmp_pulse: trigger_output_d = ch1_event; // RULE_20
			mms_ch1_ref: trigger_output_d = trig_in.ch1_reference;
			mms_ch2_ref: trigger_output_d = trig_in.ch2_reference;
			default: trigger_output_d = 1'b0;
		endcase
	end

	// Sampling tick divider
	wire [1:0] clock_division = ctrl_one_q[ckd_lsb +: 2];
	wire [1:0] div_top = clock_division == ckd_div2 ? 2'h1 : (clock_division == ckd_div4 ? 2'h3 : 2'h0);
	wire tick_d = div_q == div_top; // RULE_10

	wire ctrl_xfer = ctrl_two_q[control_preload_enable_pos] && (sw_commute
		|| (ctrl_two_q[ccus_pos] && trig_rise)); // RULE_22
	wire chdma_d = ctrl_two_q[channel_dma_select_pos] ? update_event : ch1_event; // RULE_21

	// Read mux
	wire [15:0] status_word = {9'h000, trigger_flag_q, 5'h00, update_flag_q};
	wire [15:0] rd_word = hit_c1 ? ctrl_one_q
		: hit_c2 ? ctrl_two_q
		: hit_smc ? slave_ctrl_q
		: hit_ie ? irq_dma_q
		: hit_sr ? status_word
		: hit_cnt ? counter_q
		: hit_arr ? arr_preload_q
		: hit_cmp ? cmp_preload_q
		: hit_lck ? {14'h0000, lock_q}
		: 16'h0000;

	// ---------------------------------------------------------------
	// Sequential logic
	// ---------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		pin_one_prev_q <= trig_in.input_pin_one;
		sync1_q <= raw_trig;
		sync2_q <= sync1_q;
		trig_prev_q <= sync2_q;
		if (srst)
		begin
			ack_q <= 1'b0;
			rdata_q <= 16'h0000;
			ctrl_one_q <= ctrl_one_reset;
			ctrl_two_q <= ctrl_two_reset;
			slave_ctrl_q <= 16'h0000;
			irq_dma_q <= 16'h0000;
			lock_q <= 2'h0;
			trigger_flag_q <= 1'b0;
			update_flag_q <= 1'b0;
			gate_prev_q <= 1'b0;
			div_q <= 2'h0;
			tick_q <= 1'b0;
			trigger_output_q <= 1'b0;
			chdma_q <= 1'b0;
			ctrl_xfer_q <= 1'b0;
			ctrl_pending_q <= 1'b0;
		end
		else
		begin
			ack_q <= access;
			rdata_q <= rd_word;
			ctrl_one_q <= c1_d;
			if (hit_c2)
				ctrl_two_q <= (ctrl_two_q & ~c2_wmask)
					| (wb_req.dat & c2_wmask & ctrl_two_mask);
			if (hit_smc)
				slave_ctrl_q <= (slave_ctrl_q & ~wmask)
					| (wb_req.dat & wmask & slave_ctrl_mask);
			if (hit_ie)
				irq_dma_q <= (irq_dma_q & ~wmask) | (wb_req.dat & wmask & irq_dma_mask);
			if (hit_lck && wr_lo && !locked)
				lock_q <= wb_req.dat[1:0];
			// Hardware set wins over software clear-by-zero
			if (trig_event)
				trigger_flag_q <= 1'b1; // RULE_03
			else if (hit_sr && wr_lo && !wb_req.dat[tif_pos])
				trigger_flag_q <= 1'b0;
			if (update_req)
				update_flag_q <= 1'b1;
			else if (hit_sr && wr_lo && !wb_req.dat[0])
				update_flag_q <= 1'b0;
			gate_prev_q <= gate_open;
			div_q <= tick_d ? 2'h0 : div_q + 2'h1;
			tick_q <= tick_d;
			trigger_output_q <= trigger_output_d;
			chdma_q <= chdma_d;
			ctrl_xfer_q <= ctrl_xfer;
			ctrl_pending_q <= ctrl_pending_q ? !ctrl_xfer : (hit_c2 && wr_any);
		end
	end

	// Counter, prescaler and shadow registers
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			counter_q <= 16'h0000;
			prescale_q <= 16'h0000;
			prescale_shadow_q <= 16'h0000;
			arr_preload_q <= autoreload_reset;
			arr_shadow_q <= autoreload_reset;
			cmp_preload_q <= 16'h0000;
			cmp_shadow_q <= 16'h0000;
		end
		else
		begin
			if (hit_arr && wr_any)
				arr_preload_q <= (arr_preload_q & ~wmask) | (wb_req.dat & wmask);
			if (hit_cmp && wr_any)
				cmp_preload_q <= (cmp_preload_q & ~wmask) | (wb_req.dat & wmask);
			if (update_event)
			begin
				arr_shadow_q <= arr_preload_q; // RULE_15
				cmp_shadow_q <= cmp_preload_q;
			end
			else if (!autoreload_buffer_enable)
				arr_shadow_q <= arr_preload_q; // RULE_11
			if (reinit)
			begin
				counter_q <= 16'h0000; // RULE_01
				prescale_q <= 16'h0000;
			end
			else if (hit_cnt && wr_any)
				counter_q <= (counter_q & ~wmask) | (wb_req.dat & wmask);
			else if (run && clk_en)
			begin
				prescale_q <= pre_wrap ? 16'h0000 : prescale_q + 16'h0001;
				if (pre_wrap)
					counter_q <= overflow ? 16'h0000 : counter_q + 16'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdata_q;
	assign counter_value = counter_q;
	assign trig_out.trigger_output = trigger_output_q;
	assign trig_out.trigger_irq = trigger_flag_q && irq_dma_q[tie_pos];
	assign trig_out.trigger_dma = trigger_flag_q && irq_dma_q[tde_pos];
	assign trig_out.update_irq = update_flag_q;
	assign trig_out.update_event = trigger_output_q && (master_mode_field == mms_update);
	assign trig_out.ch_dma_strobe = chdma_q;
	assign trig_out.control_transfer = ctrl_xfer_q;
	assign trig_out.sample_tick = tick_q;
	assign trig_out.ch1_idle_level = ctrl_two_q[ch1_idle_level_pos]; // RULE_16
	assign trig_out.ch1_comp_idle_level = ctrl_two_q[ch1_comp_idle_level_pos];
	assign trig_out.ch2_idle_level = ctrl_two_q[ch2_idle_level_pos];
	assign trig_out.idle_active = !trig_in.main_output_enable; // RULE_16

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	reset_clears_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
		slave_reset |=> counter_q == 16'h0000)
		else $error("reset trigger did not clear counter");
	reset_update_a: assert property (@(posedge clock) disable iff (srst) // RULE_02
		(slave_reset && !update_source_restrict && !update_disable) |=> update_flag_q)
		else $error("reset trigger gave no update");
	flag_set_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
		trig_event |=> trigger_flag_q)
		else $error("trigger flag not set");
	gate_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
		(mode_gated && !counter_enable_bit && !(hit_cnt && wr_any) && !reinit)
		|=> $stable(counter_q))
		else $error("gated counter moved without enable");
	trig_start_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
		trig_start |=> ctrl_one_q[cen_pos])
		else $error("trigger mode did not set enable");
	one_pulse_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
		(one_pulse_mode && update_event) |=> !ctrl_one_q[cen_pos])
		else $error("one-pulse did not stop counter");
	update_disable_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_14
		(update_disable && autoreload_buffer_enable && !(wr_lo && hit_c1)) |=> $stable(arr_shadow_q))
		else $error("shadow changed with updates disabled");
	lock_ois_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
		locked |=> $stable(ctrl_two_q[ch2_idle_level_pos:ch1_idle_level_pos]))
		else $error("idle bits changed under lock");
	enable_out_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		(master_mode_field == mms_enable && (counter_enable_bit || (mode_gated && trig_level))) |=> trigger_output_q)
		else $error("enable trigger output missing");
endmodule : timer_slave_sync_control

// File: tb/trigger_source_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Trigger pins, chained timers and debug halt seen by the block
// ---------------------------------------------------------------
module trigger_source_model (
	// Clock
	input wire logic clock,
	// Commands: pin one, pin two, halted, freeze, output enable
	input wire logic [4:0] cmd,
	// Trigger sources
	output slave_sync_pkg::trig_in_type trig_in
);
	import slave_sync_pkg::*;
	integer seed = 32'h45e4;
	logic [31:0] r;

	// Chained timers toggle at random; pins follow commands a cycle late
	always @(posedge clock)
	begin
		r = $random(seed);
		trig_in.internal_trigger <= r[3:0];
		trig_in.ch1_reference <= r[4];
		trig_in.ch2_reference <= r[5];
		trig_in.ch1_match <= r[6] & r[7];
		trig_in.input_pin_one <= cmd[0];
		trig_in.input_pin_two <= cmd[1];
		trig_in.debug_halted <= cmd[2];
		trig_in.debug_halt_freeze <= cmd[3];
		trig_in.main_output_enable <= cmd[4];
	end
endmodule : trigger_source_model

// File: tb/timer_slave_sync_control_tb.sv
`timescale 1ns/100ps
module timer_slave_sync_control_tb;
	import slave_sync_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	wb_req_type wb_req = '0;
	wb_rsp_type wb_rsp;
	trig_in_type trig_in;
	trig_out_type trig_out;
	logic [15:0] counter_value;
	logic [4:0] cmd = 5'h10;
	logic [15:0] expq[$];
	logic [15:0] c0;
	logic [15:0] v;
	integer seed = 32'h45e4;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;

	timer_slave_sync_control i_timer_slave_sync_control (
		.clock(clock), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.trig_in(trig_in), .trig_out(trig_out),
		.counter_value(counter_value));
	trigger_source_model i_trigger_source_model (
		.clock(clock), .cmd(cmd), .trig_in(trig_in));

	always #12.5 clock = ~clock;

	// ---------------------------------------------------------------
	// Checks and bus tasks
	// ---------------------------------------------------------------
	task complete_run;
	begin
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask : complete_run

	task check(input logic ok, input string msg);
	begin
		n_tests++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	end
	endtask : check

	task wb_cycle(input logic [7:0] a, input logic we, input logic [15:0] d);
		int n;
	begin
		n = 0;
		wb_req <= '{adr: a, dat: d, sel: 2'b11, we: we, cyc: 1'b1, stb: 1'b1};
		@(posedge clock);
		while (wb_rsp.ack !== 1'b1 && n < 50)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= 50)
			fails++;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
		@(posedge clock);
	end
	endtask : wb_cycle

	task wr(input logic [7:0] a, input logic [15:0] d);
		wb_cycle(a, 1'b1, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [15:0] e);
	begin
		expq.push_back(e);
		wb_cycle(a, 1'b0, 16'h0000);
	end
	endtask : rd

	task pins(input logic [4:0] c, input int n);
	begin
		cmd <= c;
		repeat (n) @(posedge clock);
	end
	endtask : pins

	// Read results leave the queue as their ack appears
	always @(posedge clock)
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0)
			check(expq.size() > 0 && wb_rsp.dat === expq.pop_front(), "read");

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			complete_run;
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rd(ctrl_one_offset, ctrl_one_reset);
		rd(ctrl_two_offset, ctrl_two_reset);
		rd(autoreload_offset, autoreload_reset);
		rd(8'h3C, 16'h0000);
		v = $random(seed) & 16'h018F;
		wr(ctrl_one_offset, v);
		rd(ctrl_one_offset, v);
		v = $random(seed) & ctrl_two_mask;
		wr(ctrl_two_offset, v);
		rd(ctrl_two_offset, v);
		for (int k = 0; k < 3; k++)
		begin
			wr(ctrl_one_offset, 16'(k) << ckd_lsb);
			c0 = 16'h0000;
			repeat (16)
			begin
				@(posedge clock);
				c0 = c0 + 16'(trig_out.sample_tick);
			end
			check(c0 === (16'h0010 >> k), "tick period");
		end
		// Reset mode on pin one
		wr(irq_dma_enable_offset, irq_dma_mask);
		wr(slave_ctrl_offset, 16'h0054);
		wr(ctrl_one_offset, 16'h0001);
		pins(5'h10, 30);
		check(counter_value > 16'h0014, "counting");
		wr(status_offset, 16'h0000);
		pins(5'h11, 6);
		check(counter_value < 16'h0006, "reset trigger");
		check(trig_out.update_irq === 1'b1, "update on reset");
		check(trig_out.trigger_irq & trig_out.trigger_dma, "flag");
		wr(ctrl_one_offset, 16'h0005);
		pins(5'h10, 20);
		wr(status_offset, 16'h0000);
		pins(5'h11, 6);
		check(trig_out.update_irq === 1'b0, "restricted update");
		check(counter_value < 16'h0006, "reset kept");
		// Gated mode
		wr(ctrl_one_offset, 16'h0000);
		wr(ctrl_two_offset, 16'h0010);
		wr(slave_ctrl_offset, 16'h0055);
		pins(5'h11, 6);
		check(trig_out.trigger_output === 1'b1, "enable output");
		c0 = counter_value;
		pins(5'h11, 8);
		check(counter_value === c0, "gate without enable");
		pins(5'h10, 4);
		wr(ctrl_one_offset, 16'h0001);
		wr(status_offset, 16'h0000);
		check(trig_out.trigger_irq === 1'b0, "flag clear");
		pins(5'h11, 6);
		check(trig_out.trigger_irq === 1'b1, "gate open flag");
		wr(status_offset, 16'h0000);
		pins(5'h10, 6);
		check(trig_out.trigger_irq === 1'b1, "gate close flag");
		c0 = counter_value;
		pins(5'h10, 8);
		check(counter_value === c0 && c0 !== 16'h0000, "gate hold");
		// Trigger mode on pin two
		wr(ctrl_one_offset, 16'h0000);
		wr(slave_ctrl_offset, 16'h0066);
		pins(5'h12, 8);
		rd(ctrl_one_offset, 16'h0001);
		check(counter_value !== c0, "trigger start");
		// One pulse and debug freeze
		wr(slave_ctrl_offset, 16'h0000);
		wr(autoreload_offset, 16'h0010);
		wr(ctrl_one_offset, 16'h0009);
		pins(5'h10, 40);
		rd(ctrl_one_offset, 16'h0008);
		wr(ctrl_one_offset, 16'h0001);
		pins(5'h1C, 4);
		c0 = counter_value;
		pins(5'h1C, 8);
		check(counter_value === c0, "debug freeze");
		pins(5'h14, 4);
		check(counter_value !== c0, "debug run");
		// Idle levels and lock
		wr(ctrl_two_offset, 16'h0700);
		rd(ctrl_two_offset, 16'h0700);
		pins(5'h00, 3);
		check(trig_out.idle_active & trig_out.ch1_idle_level &
			trig_out.ch1_comp_idle_level & trig_out.ch2_idle_level,
			"idle levels");
		pins(5'h10, 3);
		check(trig_out.idle_active === 1'b0, "outputs live");
		wr(lock_level_offset, 16'h0001);
		wr(ctrl_two_offset, 16'h0000);
		rd(ctrl_two_offset, 16'h0700);
		repeat (4) @(posedge clock);
		complete_run;
	end
endmodule : timer_slave_sync_control_tb
